// [pkg/rscw_pkg.sv]
// Package of constants and types for the serially programmed receiver control word.
// Behaviour
// - Auto-poll enable at 0 (reset) keeps the receiver awake; at 1 it alternates sleep and wake-up polling.
// - Fast bandwidth select at 0 (reset) picks the normal demodulator filters; at 1 the fast set.
// - The squelch control bit resets to 0, squelch off, and the host must never write it to 1.
// - With the watchdog disable bit at 0 the poll watchdog runs: code 11 or 01 gives 5 ms, 10 gives 10 ms, 00 20 ms.
// - With the watchdog disable bit at 1 there is no watchdog and the poll period is unlimited.
// - The RSSI offset bit at 0 (reset) adds no offset; at 1 it asks for a +200 mV offset.
// - The two bandwidth selects, strapped or serial, pick 1712, 3425, 6850 or 13700 Hz for low/low to high/high.
// - A high serial clock releases the data pin; clock low then high with data low, then data high then low, starts.
// - Data low, high, low with the clock high, then clock low, ends programming and the pin drives again.
// - While polling, a watchdog timeout sends the device back to sleep; disabled, only good or bad bits or clearing auto-poll decide.
package rscw_pkg;
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned WORD_W      = 20;
  localparam int unsigned CNT_W       = 5;
  localparam int unsigned WD_W        = 20;
  localparam int unsigned WD_SHORT_US = 5000;
  localparam int unsigned WD_MID_US   = 10000;
  localparam int unsigned WD_LONG_US  = 20000;
  localparam logic [19:0] CTRL_RESET  = 20'h00078;
  localparam logic [1:0]  BW_DEFAULT  = 2'h3;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;

  // Layout of the control word, bit 19 first.
  typedef struct packed {
    logic       rssi_offset_enable;
    logic       poll_watchdog_disable;
    logic       squelch_control;
    logic       fast_bw_select;
    logic       autopoll_enable;
    logic [9:0] upper_cfg;
    logic       bw_code_msb;
    logic       bw_code_lsb;
    logic [2:0] low_cfg;
  } rscw_ctrl_t;

  typedef struct packed {
    logic [1:0] poll_state;
    logic       link_busy;
    logic [1:0] bw_eff;
    logic [4:0] last_bits;
  } rscw_status_t;

  typedef enum {F_IDLE, F_REL, F_LOW, F_CHI, F_DHI, F_BITS, F_STP1, F_STP2} rscw_frame_t;
  typedef enum {P_AWAKE, P_SLEEP, P_POLL} rscw_poll_t;
endpackage : rscw_pkg

// [hw/rscw_link.sv]
// Serial clock domain capture of programming bits and a count of clock rises.
`timescale 1ns/1ns
module rscw_link (
  input  wire logic                     sclk,
  input  wire logic                     presetn,
  input  wire logic                     sdata_i,
  output logic [rscw_pkg::CNT_W-1:0]    rise_count,
  output logic [rscw_pkg::WORD_W-1:0]   shift_word
);
  import rscw_pkg::*;

  // Both outputs only move on a clock rise, so they sit still while the
  // serial clock is high or low, which is when the other domain reads them.
  always_ff @(posedge sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_count <= '0;
      shift_word <= '0;
    end
    else
    begin
      shift_word <= {shift_word[WORD_W-2:0], sdata_i};
      rise_count <= rise_count + 1'b1;
    end
  end

  chk_bit_shift_in: assert property (
    @(posedge sclk) disable iff (!presetn)
    ##1 (shift_word[0] == $past(sdata_i)) && (shift_word[1] == $past(shift_word[0])))
    else $error("Serial bit not shifted in at the clock rise.");
endmodule : rscw_link

// [hw/rscw_top.sv]
// Top of the control word block: link framing, control word, poll control and APB access.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module rscw_top #(
  parameter int unsigned WD_SHORT_CYC = rscw_pkg::WD_SHORT_US * rscw_pkg::CLK_MHZ,
  parameter int unsigned WD_MID_CYC   = rscw_pkg::WD_MID_US * rscw_pkg::CLK_MHZ,
  parameter int unsigned WD_LONG_CYC  = rscw_pkg::WD_LONG_US * rscw_pkg::CLK_MHZ
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          sclk,
  input  wire logic          sdata_i,
  output logic               sdata_o,
  output logic               sdata_oe_n,
  input  wire logic          bw_jumper_first,
  input  wire logic          bw_jumper_second,
  input  wire logic          demod_data,
  input  wire logic          data_edge,
  input  wire logic          bitcheck_good,
  input  wire logic          bitcheck_bad,
  input  wire logic          sleep_done,
  output rscw_pkg::rscw_ctrl_t ctrl_word,
  output logic [1:0]         demod_bw_code,
  output logic               fast_bw,
  output logic               squelch_on,
  output logic               rssi_offset_on,
  output logic               rx_awake,
  output logic               poll_active
);
  import rscw_pkg::*;

  localparam int unsigned SYNC_W = 4 + CNT_W + WORD_W;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [CNT_W-1:0]  link_cnt;
  logic [WORD_W-1:0] link_word;
  logic              s_clk;
  logic              s_din;
  logic              bw_select_first;
  logic              bw_select_second;
  logic [CNT_W-1:0]  s_cnt;
  logic [WORD_W-1:0] s_word;
  logic              clk_q;
  logic              din_q;
  rscw_frame_t       frame;
  rscw_frame_t       next_frame;
  rscw_poll_t        poll;
  rscw_poll_t        next_poll;
  logic [CNT_W-1:0]  base_cnt;
  logic [CNT_W-1:0]  last_bits;
  logic [CNT_W-1:0]  nbits_raw;
  logic [CNT_W-1:0]  nbits;
  logic              start_done;
  logic              stop_done;
  logic              stop_edge;
  rscw_ctrl_t        load_word;
  rscw_ctrl_t        next_ctrl;
  logic [1:0]        ser_bw;
  logic [1:0]        bw_eff;
  logic              ap_on;
  logic              ap_q;
  logic              ap_rise;
  logic              wd_off;
  logic [WD_W-1:0]   wd_cnt;
  logic [WD_W-1:0]   next_wd;
  logic              wd_hit;
  logic              apb_setup;
  logic              hit_ctrl;
  logic              hit_stat;
  logic              mapped;
  logic              apb_wr_ctrl;
  rscw_status_t      stat_word;
  logic [31:0]       rd_mux;

  function automatic logic [WORD_W-1:0] merge_bits(
    input logic [WORD_W-1:0] old,
    input logic [WORD_W-1:0] fresh,
    input logic [CNT_W-1:0]  n
  );
    logic [WORD_W-1:0] mask;
    mask = ~({WORD_W{1'b1}} << n);
    merge_bits = (old & ~mask) | (fresh & mask);
  endfunction : merge_bits

  function automatic logic [WD_W-1:0] wd_limit(input logic [1:0] code);
    case (code)
      2'h3, 2'h1: wd_limit = WD_W'(WD_SHORT_CYC);
      2'h2:       wd_limit = WD_W'(WD_MID_CYC);
      default:    wd_limit = WD_W'(WD_LONG_CYC);
    endcase
  endfunction : wd_limit

  rscw_link u_link (
    .sclk       (sclk),
    .presetn    (presetn),
    .sdata_i    (sdata_i),
    .rise_count (link_cnt),
    .shift_word (link_word)
  );

  // Pins and the serial clock domain come over by two flops; the count and word only
  // change on a serial clock rise and are read only while the synchronised clock stands still.
  assign sync_raw = {sclk, sdata_i, bw_jumper_second, bw_jumper_first, link_cnt, link_word};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
      clk_q  <= 1'b0;
      din_q  <= 1'b0;
    end
    else if (ce)
    begin
      sync_a <= sync_raw;
      sync_b <= sync_a;
      clk_q  <= s_clk;
      din_q  <= s_din;
    end
  end

  assign s_clk            = sync_b[SYNC_W-1];
  assign s_din            = sync_b[SYNC_W-2];
  assign bw_select_second = sync_b[SYNC_W-3];
  assign bw_select_first  = sync_b[SYNC_W-4];
  assign s_cnt            = sync_b[WORD_W +: CNT_W];
  assign s_word           = sync_b[WORD_W-1:0];

  // Framing of the start and stop sequences seen from the synchronised pins.
  assign start_done = (frame == F_DHI) && s_clk && !s_din;
  assign stop_edge  = s_clk && clk_q && s_din && !din_q;
  assign stop_done  = (frame == F_STP2) && !s_clk;

  always_comb
  begin
    next_frame = frame;
    case (frame)
      F_IDLE: if (s_clk) next_frame = F_REL;
      F_REL:  if (!s_clk) next_frame = F_LOW;
      F_LOW:  if (s_clk) next_frame = s_din ? F_REL : F_CHI;
      F_CHI:
      begin
        if (!s_clk) next_frame = F_LOW;
        else if (s_din) next_frame = F_DHI;
      end
      F_DHI:
      begin
        if (!s_clk) next_frame = F_LOW;
        else if (!s_din) next_frame = F_BITS;
      end
      F_BITS: if (stop_edge) next_frame = F_STP1;
      F_STP1:
      begin
        if (!s_clk) next_frame = F_BITS;
        else if (!s_din) next_frame = F_STP2;
      end
      F_STP2: if (!s_clk) next_frame = F_IDLE;
      default: next_frame = F_IDLE;
    endcase
  end

  // Bits counted from the end of the start sequence replace the low end of the word; the
  // last bit is always bit 0, so the count places the first. Beyond a word, up to 31 bits, the last twenty stay.
  assign nbits_raw = s_cnt - base_cnt;
  assign nbits     = (nbits_raw > CNT_W'(WORD_W)) ? CNT_W'(WORD_W) : nbits_raw;
  assign load_word = merge_bits(ctrl_word, s_word, nbits);

  // A serial load wins over a register write in the same cycle.
  assign next_ctrl = stop_done ? load_word : apb_wr_ctrl ? rscw_ctrl_t'(pwdata[WORD_W-1:0]) : ctrl_word;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame     <= F_IDLE;
      base_cnt  <= '0;
      last_bits <= '0;
      ctrl_word <= CTRL_RESET;
    end
    else if (ce)
    begin
      frame     <= next_frame;
      base_cnt  <= start_done ? s_cnt : base_cnt;
      last_bits <= stop_done ? nbits : last_bits;
      ctrl_word <= next_ctrl;
    end
  end

  // Strap pins only steer the bandwidth while the serial field holds its default.
  assign ser_bw = {ctrl_word.bw_code_msb, ctrl_word.bw_code_lsb};
  assign bw_eff = (ser_bw == BW_DEFAULT) ? {bw_select_second, bw_select_first} : ser_bw;

  // Poll control. Once awake with auto-poll on, the receiver stays awake
  // until auto-poll is cleared and set again, so only a rising edge sleeps it.
  assign ap_on   = ctrl_word.autopoll_enable;
  assign wd_off  = ctrl_word.poll_watchdog_disable;
  assign ap_rise = ap_on && !ap_q;
  assign wd_hit  = (wd_cnt == wd_limit(bw_eff) - 1'b1);

  always_comb
  begin
    next_poll = poll;
    case (poll)
      P_AWAKE: if (ap_rise) next_poll = P_SLEEP;
      P_SLEEP:
      begin
        if (!ap_on) next_poll = P_AWAKE;
        else if (sleep_done) next_poll = P_POLL;
      end
      P_POLL:
      begin
        if (!ap_on || bitcheck_good) next_poll = P_AWAKE;
        else if (bitcheck_bad || (wd_hit && !wd_off)) next_poll = P_SLEEP;
      end
      default: next_poll = P_AWAKE;
    endcase
  end

  // Any data transition restarts the watchdog; disabled, it saturates.
  assign next_wd = ((poll != P_POLL) || data_edge) ? '0 : (wd_cnt == '1) ? wd_cnt : wd_cnt + 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      poll   <= P_AWAKE;
      ap_q   <= 1'b0;
      wd_cnt <= '0;
    end
    else if (ce)
    begin
      poll   <= next_poll;
      ap_q   <= ap_on;
      wd_cnt <= next_wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      demod_bw_code  <= BW_DEFAULT;
      fast_bw        <= 1'b0;
      squelch_on     <= 1'b0;
      rssi_offset_on <= 1'b0;
      rx_awake       <= 1'b1;
      poll_active    <= 1'b0;
      sdata_o        <= 1'b0;
      sdata_oe_n     <= 1'b0;
    end
    else if (ce)
    begin
      demod_bw_code  <= bw_eff;
      fast_bw        <= ctrl_word.fast_bw_select;
      squelch_on     <= ctrl_word.squelch_control;
      rssi_offset_on <= ctrl_word.rssi_offset_enable;
      rx_awake       <= (next_poll == P_AWAKE);
      poll_active    <= (next_poll == P_POLL);
      // Data is blanked while asleep or polling, and the pin is let go for programming.
      sdata_o        <= (next_poll == P_AWAKE) && (next_frame == F_IDLE) && demod_data;
      sdata_oe_n     <= (next_frame != F_IDLE);
    end
  end

  // APB slave with no wait states while ce is high; read data is fetched in the setup phase.
  assign apb_setup   = psel && !penable;
  assign hit_ctrl    = (paddr == ADDR_CTRL);
  assign hit_stat    = (paddr == ADDR_STATUS);
  assign mapped      = hit_ctrl || hit_stat;
  assign apb_wr_ctrl = psel && penable && pready && pwrite && hit_ctrl;
  assign stat_word   = '{poll_state: 2'(poll), link_busy: (frame != F_IDLE), bw_eff: bw_eff, last_bits: last_bits};
  assign rd_mux      = hit_ctrl ? {12'h000, ctrl_word} : hit_stat ? {22'h0, stat_word} : 32'h00000000;

  // Ready follows the enable one cycle late, so a frozen block stretches a transfer, but a write that completes in the first frozen cycle is dropped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= ce;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      prdata  <= (apb_setup && !pwrite) ? rd_mux : prdata;
      pslverr <= apb_setup && !mapped;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ap_off_awake: assert property (ce && !ap_on |=> rx_awake && !poll_active)
    else $error("Receiver not awake with auto-poll off.");
  chk_fast_bw_follow: assert property (ce && $rose(ctrl_word.fast_bw_select) |=> fast_bw)
    else $error("Fast bandwidth output missed the control bit.");
  chk_squelch_off: assert property (ce && !ctrl_word.squelch_control |=> !squelch_on)
    else $error("Squelch turned on without its control bit.");
  chk_wd_timeout_sleep: assert property (
    ce && poll == P_POLL && wd_hit && !wd_off && ap_on && !bitcheck_good
    |=> !rx_awake && !poll_active && poll == P_SLEEP)
    else $error("Watchdog expiry did not return to sleep.");
  chk_wd_off_stays: assert property (
    ce && poll == P_POLL && wd_off && ap_on && !bitcheck_good && !bitcheck_bad
    |=> poll_active)
    else $error("Polling ended with the watchdog disabled.");
  chk_rssi_follow: assert property (ce |=> rssi_offset_on == $past(ctrl_word.rssi_offset_enable))
    else $error("RSSI offset output does not follow the control bit.");
  chk_bw_serial_code: assert property (ce && ser_bw != BW_DEFAULT |=> demod_bw_code == $past(ser_bw))
    else $error("Bandwidth code ignores the serial field.");
  chk_pin_release: assert property (ce && frame == F_IDLE && s_clk |=> sdata_oe_n)
    else $error("Data pin not released on a high serial clock.");
  chk_stop_loads: assert property (
    ce && stop_done |=> ctrl_word == $past(load_word) && !sdata_oe_n)
    else $error("Stop sequence did not load the word and drive the pin.");
  chk_bad_bits_sleep: assert property (
    ce && poll == P_POLL && bitcheck_bad && !bitcheck_good && ap_on
    |=> !poll_active ##1 !rx_awake)
    else $error("Bad bits did not return the receiver to sleep.");
endmodule : rscw_top

// [testbench/rscw_host.sv]
// Behavioural host that programs the control word over the serial clock and the data pin.
`timescale 1ns/1ns
module rscw_host (
  output logic      sclk,
  input  wire logic sdata_o,
  input  wire logic sdata_oe_n,
  output wire logic pin,
  output logic      rel_ok
);
  logic lclk = 1'h0;
  logic drv  = 1'h0;
  logic d    = 1'h0;
  logic last = 1'h0;

  // Each phase lasts two link periods, well above the minimum the synchroniser needs.
  always #40 lclk = ~lclk;
  initial sclk = 1'h0;
  initial rel_ok = 1'h1;

  // A pin nobody drives shows a changing level, so a stale value can never pass for data.
  assign pin = !sdata_oe_n ? sdata_o : (drv ? d : ~last);
  always @(posedge lclk) last <= pin;

  task step;
    repeat (2) @(posedge lclk);
  endtask : step

  task send_frame(input logic [19:0] w, input int n);
    int i;
    rel_ok = 1'h1;
    sclk = 1'h1;
    step;
    drv = 1'h1;
    d = 1'h0;
    step;
    sclk = 1'h0;
    step;
    sclk = 1'h1;
    step;
    d = 1'h1;
    step;
    d = 1'h0;
    step;
    for (i = n - 1; i >= 0; i--)
    begin
      sclk = 1'h0;
      step;
      d = w[i];
      step;
      sclk = 1'h1;
      step;
      if (sdata_oe_n !== 1'h1) rel_ok = 1'h0;
    end
    d = 1'h0;
    step;
    d = 1'h1;
    step;
    d = 1'h0;
    step;
    sclk = 1'h0;
    step;
    drv = 1'h0;
  endtask : send_frame
endmodule : rscw_host

// [testbench/rx_serial_control_word_tb_top.sv]
// Self-checking bench for the serially programmed receiver control word.
`timescale 1ns/1ns
module rx_serial_control_word_tb_top;
  import rscw_pkg::*;
  logic             pclk = 1'h0;
  logic             presetn = 1'h0;
  logic             psel = 1'h0;
  logic             penable = 1'h0;
  logic             pwrite = 1'h0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic             jf = 1'h1;
  logic             js = 1'h1;
  logic             dd = 1'h0;
  logic [3:0]       ev = 4'h0;
  logic             pready, pslverr, sclk, pin, sdata_o, sdata_oe_n, rel_ok;
  logic [31:0]      prdata, rd;
  logic             er;
  rscw_ctrl_t       ctrl_word;
  logic [1:0]       bw_code;
  logic             fast_bw, squelch_on, rssi_on, rx_awake, poll_active;
  int               fails = 0;
  int               n_compared = 0;

  always #10 pclk = ~pclk;

  rscw_top #(.WD_SHORT_CYC(20), .WD_MID_CYC(40), .WD_LONG_CYC(80)) u_rscw_top (
    .pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sclk(sclk), .sdata_i(pin), .sdata_o(sdata_o), .sdata_oe_n(sdata_oe_n),
    .bw_jumper_first(jf), .bw_jumper_second(js), .demod_data(dd), .data_edge(ev[1]),
    .bitcheck_good(ev[2]), .bitcheck_bad(ev[3]), .sleep_done(ev[0]), .ctrl_word(ctrl_word),
    .demod_bw_code(bw_code), .fast_bw(fast_bw), .squelch_on(squelch_on), .rssi_offset_on(rssi_on),
    .rx_awake(rx_awake), .poll_active(poll_active));

  rscw_host u_rscw_host (.sclk(sclk), .sdata_o(sdata_o), .sdata_oe_n(sdata_oe_n), .pin(pin), .rel_ok(rel_ok));

  task check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'h1)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task pulse(input int b);
    ev[b] <= 1'h1;
    @(posedge pclk);
    ev <= 4'h0;
  endtask : pulse

  // The request is held until pready is seen high; an answer later than 49 access cycles ends the transfer and fails the check.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    er = pslverr;
    check(k < 50, "no bus answer");
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task t_reset;
    check(ctrl_word === CTRL_RESET, "control word reset");
    check({fast_bw, squelch_on, rssi_on, poll_active, rx_awake} === 5'h01, "mode reset");
    dd <= 1'h1;
    apb(1'h0, ADDR_CTRL, 32'h0);
    check(rd === 32'h00078 && er === 1'h0, "control read");
    check(sdata_o === 1'h1, "data passes while awake");
    apb(1'h1, 12'h008, 32'hFFFFFFFF);
    check(er === 1'h1 && ctrl_word === CTRL_RESET, "unmapped write");
    apb(1'h0, 12'h008, 32'h0);
    check(rd === 32'h0 && er === 1'h1, "unmapped read");
  endtask : t_reset

  task t_apb_modes;
    apb(1'h1, ADDR_CTRL, 32'hFFF90078);
    cyc(2);
    check(fast_bw === 1'h1 && rssi_on === 1'h1 && squelch_on === 1'h0, "fast and offset on");
    apb(1'h0, ADDR_CTRL, 32'h0);
    check(rd === 32'h00090078, "control readback");
    apb(1'h1, ADDR_CTRL, 32'h00000078);
    cyc(2);
    check(fast_bw === 1'h0 && rssi_on === 1'h0, "fast and offset off");
  endtask : t_apb_modes

  task t_serial;
    u_rscw_host.send_frame(20'h93C5A, 20);
    cyc(10);
    check(ctrl_word === 20'h93C5A, "full serial word");
    check(rel_ok === 1'h1 && sdata_oe_n === 1'h0, "pin released then driven");
    check(fast_bw === 1'h1 && rssi_on === 1'h1, "serial mode bits");
    u_rscw_host.send_frame(20'h00005, 3);
    cyc(10);
    check(ctrl_word === 20'h93C5D, "short serial word keeps upper bits");
    check(sdata_oe_n === 1'h0, "pin driven after stop");
    apb(1'h0, ADDR_STATUS, 32'h0);
    check(rd[4:0] === 5'h03, "bit count of last load");
  endtask : t_serial

  task t_straps;
    int i;
    apb(1'h1, ADDR_CTRL, 32'h00000078);
    for (i = 0; i < 4; i++)
    begin
      jf <= i[0];
      js <= i[1];
      cyc(6);
      check(bw_code === i[1:0], "strap bandwidth");
    end
    apb(1'h1, ADDR_CTRL, 32'h00000068);
    cyc(2);
    check(bw_code === 2'h1, "serial bandwidth overrides straps");
  endtask : t_straps

  task t_poll;
    apb(1'h1, ADDR_CTRL, 32'h00008078);
    cyc(2);
    check(rx_awake === 1'h0 && poll_active === 1'h0, "auto-poll sleeps");
    check(sdata_o === 1'h0, "data blanked while asleep");
    pulse(0);
    cyc(2);
    check(poll_active === 1'h1, "sleep done polls");
    cyc(14);
    check(poll_active === 1'h1, "short watchdog not yet");
    cyc(10);
    check(poll_active === 1'h0 && rx_awake === 1'h0, "short watchdog expired");
    pulse(0);
    cyc(12);
    pulse(1);
    cyc(14);
    check(poll_active === 1'h1, "data edge restarts watchdog");
    cyc(12);
    check(poll_active === 1'h0, "restarted watchdog expired");
    apb(1'h1, ADDR_CTRL, 32'h00008060);
    pulse(0);
    cyc(70);
    check(poll_active === 1'h1, "long watchdog not yet");
    cyc(20);
    check(poll_active === 1'h0, "long watchdog expired");
    apb(1'h1, ADDR_CTRL, 32'h00008070);
    pulse(0);
    cyc(30);
    check(poll_active === 1'h1 && bw_code === 2'h2, "mid watchdog not yet");
    cyc(20);
    check(poll_active === 1'h0, "mid watchdog expired");
    apb(1'h1, ADDR_CTRL, 32'h00048060);
    pulse(0);
    cyc(200);
    check(poll_active === 1'h1, "disabled watchdog keeps polling");
    pulse(2);
    cyc(2);
    check(rx_awake === 1'h1 && poll_active === 1'h0, "good bits wake");
    apb(1'h1, ADDR_CTRL, 32'h00040060);
    apb(1'h1, ADDR_CTRL, 32'h00048060);
    pulse(0);
    cyc(2);
    pulse(3);
    cyc(2);
    check(rx_awake === 1'h0 && poll_active === 1'h0, "bad bit sleeps");
    apb(1'h1, ADDR_CTRL, 32'h00040060);
    cyc(2);
    check(rx_awake === 1'h1 && sdata_o === 1'h1, "auto-poll off wakes");
  endtask : t_poll

  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #200000;
    fails++;
    $display("CHECK FAILED at %0t: run did not complete", $time);
    finish_test;
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_apb_modes;
    t_serial;
    t_straps;
    t_poll;
    finish_test;
  end
endmodule : rx_serial_control_word_tb_top
